// ### core/blitgc_color_sel.sv
// Purpose: decode of the blit operation and selection of the colors it uses
// Assumes: pure combinational, registered by the parent
// Notes: codes outside the decoded set use no color at all
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// color usage decode
//==============================================================
module blitgc_color_sel (
  input wire logic [3:0] op_code,
  input wire logic bpp16,
  input wire logic [15:0] fg_raw,
  input wire logic [15:0] bg_raw,
  output logic [15:0] fg_eff,
  output logic [15:0] bg_eff,
  output logic solid_fill,
  output logic color_expand,
  output logic key_en,
  output logic pattern_op
);

  // upper byte kept only in 16 bpp
  wire logic [15:0] depth_mask;
  // decoded operation groups
  wire logic is_solid;
  wire logic is_expand;
  wire logic is_key;

  assign depth_mask = bpp16 ? 16'hffff : 16'h00ff;
  assign is_solid = (op_code == blitgc_pkg::OP_SOLID_FILL);
  assign is_expand = (op_code == blitgc_pkg::OP_COLOR_EXP) ||
                     (op_code == blitgc_pkg::OP_COLOR_EXP_TRANS) ||
                     (op_code == blitgc_pkg::OP_MOVE_EXP) ||
                     (op_code == blitgc_pkg::OP_MOVE_EXP_TRANS);
  assign is_key = (op_code == blitgc_pkg::OP_TRANS_MOVE_POS) ||
                  (op_code == blitgc_pkg::OP_PAT_TRANS) ||
                  (op_code == blitgc_pkg::OP_COLOR_EXP_TRANS) ||
                  (op_code == blitgc_pkg::OP_MOVE_EXP_TRANS);
  // fill value for solid fill, foreground for expansion
  assign fg_eff = (is_solid || is_expand) ? (fg_raw & depth_mask) : 16'h0000;
  // background for expansion, key for transparency
  assign bg_eff = (is_expand || is_key) ? (bg_raw & depth_mask) : 16'h0000;
  assign solid_fill = is_solid;
  assign color_expand = is_expand;
  assign key_en = is_key;
  assign pattern_op = (op_code == blitgc_pkg::OP_PAT_ROP) ||
                      (op_code == blitgc_pkg::OP_PAT_TRANS);

endmodule
`default_nettype wire

// ### core/blitgc_pkg.sv
// Purpose: shared constants and types of the blit geometry and color register set
// Assumes: 32-bit bus words, one byte register in the low lane of each word
// Notes: byte address of a register is four times its index
//==============================================================
// blit geometry and color constants
//==============================================================
package blitgc_pkg;

  // number of writable byte registers held in the bank
  localparam int unsigned NREG = 14;
  // width of a register index taken from the byte address
  localparam int unsigned IDX_W = 10;

  //==============================================================
  // register indices
  //==============================================================
  localparam logic [9:0] IDX_DEST_LO = 10'h108;
  localparam logic [9:0] IDX_DEST_MID = 10'h109;
  localparam logic [9:0] IDX_DEST_HI = 10'h10a;
  localparam logic [9:0] IDX_OFS_LO = 10'h10c;
  localparam logic [9:0] IDX_OFS_HI = 10'h10d;
  localparam logic [9:0] IDX_WIDTH_LO = 10'h110;
  localparam logic [9:0] IDX_WIDTH_HI = 10'h111;
  localparam logic [9:0] IDX_HEIGHT_LO = 10'h112;
  localparam logic [9:0] IDX_HEIGHT_HI = 10'h113;
  localparam logic [9:0] IDX_BG_LO = 10'h114;
  localparam logic [9:0] IDX_BG_HI = 10'h115;
  localparam logic [9:0] IDX_FG_LO = 10'h118;
  localparam logic [9:0] IDX_FG_HI = 10'h119;
  localparam logic [9:0] IDX_OP_CTRL = 10'h11c;
  // read-only status, not part of the writable array
  localparam logic [9:0] IDX_STATUS = 10'h11d;

  //==============================================================
  // slots of each register inside the array
  //==============================================================
  localparam int unsigned SLOT_DEST_LO = 0;
  localparam int unsigned SLOT_DEST_MID = 1;
  localparam int unsigned SLOT_DEST_HI = 2;
  localparam int unsigned SLOT_OFS_LO = 3;
  localparam int unsigned SLOT_OFS_HI = 4;
  localparam int unsigned SLOT_WIDTH_LO = 5;
  localparam int unsigned SLOT_WIDTH_HI = 6;
  localparam int unsigned SLOT_HEIGHT_LO = 7;
  localparam int unsigned SLOT_HEIGHT_HI = 8;
  localparam int unsigned SLOT_BG_LO = 9;
  localparam int unsigned SLOT_BG_HI = 10;
  localparam int unsigned SLOT_FG_LO = 11;
  localparam int unsigned SLOT_FG_HI = 12;
  localparam int unsigned SLOT_OP_CTRL = 13;

  // index of each slot, in slot order
  localparam logic [9:0] REG_IDX [NREG] = '{
    IDX_DEST_LO, IDX_DEST_MID, IDX_DEST_HI, IDX_OFS_LO, IDX_OFS_HI,
    IDX_WIDTH_LO, IDX_WIDTH_HI, IDX_HEIGHT_LO, IDX_HEIGHT_HI,
    IDX_BG_LO, IDX_BG_HI, IDX_FG_LO, IDX_FG_HI, IDX_OP_CTRL};

  // implemented bits of each slot; the rest store and read as zero
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hff, 8'hff, 8'h1f, 8'hff, 8'h07, 8'hff, 8'h03, 8'hff, 8'h03,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h1f};

  // reset value of every slot
  localparam logic [7:0] REG_RST = 8'h00;

  //==============================================================
  // field layouts
  //==============================================================
  localparam int unsigned DEST_W = 21;
  localparam int unsigned OFS_W = 11;
  localparam int unsigned SIZE_W = 10;
  localparam int unsigned COLOR_W = 16;
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_BPP16_BIT = 4;
  localparam int unsigned STAT_SOLID_BIT = 0;
  localparam int unsigned STAT_EXPAND_BIT = 1;
  localparam int unsigned STAT_KEY_BIT = 2;
  localparam int unsigned STAT_PATW_BIT = 3;
  // pattern fills need width of two pixels, i.e. width minus one of one
  localparam logic [9:0] MIN_PAT_WIDTH_M1 = 10'h001;

  //==============================================================
  // operation codes and bus states
  //==============================================================
  typedef enum logic [3:0] {
    OP_TRANS_MOVE_POS = 4'h5,
    OP_PAT_ROP = 4'h6,
    OP_PAT_TRANS = 4'h7,
    OP_COLOR_EXP = 4'h8,
    OP_COLOR_EXP_TRANS = 4'h9,
    OP_MOVE_EXP = 4'ha,
    OP_MOVE_EXP_TRANS = 4'hb,
    OP_SOLID_FILL = 4'hc
  } blitgc_op_e;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } blitgc_bus_e;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### core/blitgc_regs.sv
// Purpose: blit geometry and color registers behind an avalon-mm slave
// Assumes: single clock, synchronous active-high reset, 32-bit bus
// Notes: every output to the engine is a flip-flop
//
// Contract
// - hold 21-bit destination start address
// - destination address seeds engine write start
// - hold 11-bit line-to-line word offset
// - offset used only for rectangle addresses
// - display refresh never sees the offset
// - hold 10-bit width as pixels minus one
// - hold 10-bit height as lines minus one
// - background is expansion color and key
// - foreground is expansion and fill color
// - 16 bpp all bits, 8 bpp low byte
// - decode solid fill and color expansion codes
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// register bank top
//==============================================================
module blitgc_regs #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave, byte address
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // engine control, same clock
  input wire logic blit_start,
  input wire logic line_advance,
  // engine parameters
  output logic [20:0] blit_dest_addr,
  output logic [20:0] blit_line_start,
  output logic [10:0] blit_line_offset,
  output logic [9:0] blit_width_m1,
  output logic [9:0] blit_height_m1,
  output logic [15:0] blit_fg_color,
  output logic [15:0] blit_bg_color,
  output logic [3:0] blit_op_code,
  output logic blit_bpp16,
  output logic blit_solid_fill,
  output logic blit_color_expand,
  output logic blit_key_en
);

  //==============================================================
  // declarations
  //==============================================================
  // handshake state of the slave
  blitgc_pkg::blitgc_bus_e bus_state_r;
  blitgc_pkg::blitgc_bus_e bus_state_nxt;
  // registered bus outputs
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [1:0] response_r;
  // byte storage, one entry per register
  logic [7:0] reg_r [blitgc_pkg::NREG];
  // register index from the byte address
  wire logic [9:0] reg_idx;
  // per-slot hit and read terms
  wire logic [blitgc_pkg::NREG-1:0] hit_vec;
  wire logic [7:0] rd_term [blitgc_pkg::NREG];
  // or-chain of the read terms
  wire logic [7:0] rd_chain [blitgc_pkg::NREG+1];
  // decode results
  wire logic any_hit;
  wire logic stat_hit;
  wire logic mapped;
  wire logic req;
  wire logic wr_fire;
  wire logic [7:0] rd_byte;
  wire logic [7:0] status_byte;
  // assembled fields
  wire logic [20:0] dest_field;
  wire logic [10:0] ofs_field;
  wire logic [9:0] width_field;
  wire logic [9:0] height_field;
  wire logic [15:0] bg_field;
  wire logic [15:0] fg_field;
  wire logic [3:0] op_field;
  wire logic bpp_field;
  // color selection results
  wire logic [15:0] fg_sel;
  wire logic [15:0] bg_sel;
  wire logic solid_sel;
  wire logic expand_sel;
  wire logic key_sel;
  wire logic pattern_sel;
  // pattern fill programmed too narrow
  wire logic pat_width_bad;
  // registered engine outputs
  logic [20:0] dest_r;
  logic [20:0] line_start_r;
  logic [20:0] line_start_nxt;
  logic [10:0] ofs_r;
  logic [9:0] width_r;
  logic [9:0] height_r;
  logic [15:0] fg_r;
  logic [15:0] bg_r;
  logic [3:0] op_r;
  logic bpp_r;
  logic solid_r;
  logic expand_r;
  logic key_r;
  logic pat_bad_r;

  //==============================================================
  // address decode
  //==============================================================
  // low two address bits ignored, one register per word
  assign reg_idx = address[11:2];
  // a request is live while read or write is high
  assign req = read || write;
  // status is read-only and sits outside the array
  assign stat_hit = (reg_idx == blitgc_pkg::IDX_STATUS);
  assign any_hit = |hit_vec;
  assign mapped = any_hit || stat_hit;
  // write lands at the edge where waitrequest is seen low
  assign wr_fire = (bus_state_r == blitgc_pkg::BUS_ACK) && write && byteenable[0];

  //==============================================================
  // register storage, one entry per slot
  //==============================================================
  assign rd_chain[0] = 8'h00;
  for (genvar gi = 0; gi < blitgc_pkg::NREG; gi++) begin : g_reg
    // index match for this slot
    assign hit_vec[gi] = (reg_idx == blitgc_pkg::REG_IDX[gi]);
    // masked store: unused bits never hold a one
    always_ff @(posedge clock) begin
      if (rst) begin
        reg_r[gi] <= blitgc_pkg::REG_RST;
      end else if (wr_fire && hit_vec[gi]) begin
        reg_r[gi] <= writedata[7:0] & blitgc_pkg::REG_MASK[gi];
      end
    end
    // this slot drives the read byte only on a hit
    assign rd_term[gi] = hit_vec[gi] ? reg_r[gi] : 8'h00;
    assign rd_chain[gi+1] = rd_chain[gi] | rd_term[gi];
  end

  //==============================================================
  // read data selection
  //==============================================================
  // status shows the decoded state of the programmed operation
  assign status_byte = {4'h0, pat_bad_r, key_r, expand_r, solid_r};
  // unmapped words read as zero
  assign rd_byte = stat_hit ? status_byte : rd_chain[blitgc_pkg::NREG];

  //==============================================================
  // bus handshake
  //==============================================================
  // one wait cycle, then a single answer cycle
  // a registered waitrequest costs that wait
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      blitgc_pkg::BUS_IDLE: begin
        // request seen: answer in the next cycle
        if (req) begin
          bus_state_nxt = blitgc_pkg::BUS_ACK;
        end
      end
      blitgc_pkg::BUS_ACK: begin
        // master completes on this edge and releases
        bus_state_nxt = blitgc_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_nxt = blitgc_pkg::BUS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_state_r <= blitgc_pkg::BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // waitrequest low for exactly the answer cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= (bus_state_nxt != blitgc_pkg::BUS_ACK);
    end
  end

  // read data and response captured as the answer cycle opens
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata_r <= 32'h0000_0000;
      response_r <= blitgc_pkg::RESP_OKAY;
    end else if (bus_state_r == blitgc_pkg::BUS_IDLE && req) begin
      readdata_r <= {24'h00_0000, rd_byte};
      response_r <= mapped ? blitgc_pkg::RESP_OKAY : blitgc_pkg::RESP_SLVERR;
    end
  end

  //==============================================================
  // field assembly
  //==============================================================
  // three bytes form the destination start
  assign dest_field = {reg_r[blitgc_pkg::SLOT_DEST_HI][4:0],
                       reg_r[blitgc_pkg::SLOT_DEST_MID],
                       reg_r[blitgc_pkg::SLOT_DEST_LO]};
  // low byte plus three upper bits of line offset
  assign ofs_field = {reg_r[blitgc_pkg::SLOT_OFS_HI][2:0],
                      reg_r[blitgc_pkg::SLOT_OFS_LO]};
  // width and height stored minus one, passed as is
  assign width_field = {reg_r[blitgc_pkg::SLOT_WIDTH_HI][1:0],
                        reg_r[blitgc_pkg::SLOT_WIDTH_LO]};
  assign height_field = {reg_r[blitgc_pkg::SLOT_HEIGHT_HI][1:0],
                         reg_r[blitgc_pkg::SLOT_HEIGHT_LO]};
  // raw 16-bit colors
  assign bg_field = {reg_r[blitgc_pkg::SLOT_BG_HI],
                     reg_r[blitgc_pkg::SLOT_BG_LO]};
  assign fg_field = {reg_r[blitgc_pkg::SLOT_FG_HI],
                     reg_r[blitgc_pkg::SLOT_FG_LO]};
  // operation code and color depth select
  assign op_field = reg_r[blitgc_pkg::SLOT_OP_CTRL][blitgc_pkg::CTRL_OP_LSB +: 4];
  assign bpp_field = reg_r[blitgc_pkg::SLOT_OP_CTRL][blitgc_pkg::CTRL_BPP16_BIT];

  //==============================================================
  // color selection
  //==============================================================
  blitgc_color_sel u_color_sel (
    .op_code(op_field),
    .bpp16(bpp_field),
    .fg_raw(fg_field),
    .bg_raw(bg_field),
    .fg_eff(fg_sel),
    .bg_eff(bg_sel),
    .solid_fill(solid_sel),
    .color_expand(expand_sel),
    .key_en(key_sel),
    .pattern_op(pattern_sel)
  );

  // flag only; the engine is not stopped, software owns the limit
  assign pat_width_bad = pattern_sel &&
                         (width_field < blitgc_pkg::MIN_PAT_WIDTH_M1);

  //==============================================================
  // engine parameter outputs
  //==============================================================
  // geometry registered toward the engine
  always_ff @(posedge clock) begin
    if (rst) begin
      dest_r <= 21'h00_0000;
      ofs_r <= 11'h000;
      width_r <= 10'h000;
      height_r <= 10'h000;
    end else begin
      dest_r <= dest_field;
      ofs_r <= ofs_field;
      width_r <= width_field;
      height_r <= height_field;
    end
  end

  // colors and decoded mode registered toward the engine
  always_ff @(posedge clock) begin
    if (rst) begin
      fg_r <= 16'h0000;
      bg_r <= 16'h0000;
      op_r <= 4'h0;
      bpp_r <= 1'b0;
      solid_r <= 1'b0;
      expand_r <= 1'b0;
      key_r <= 1'b0;
      pat_bad_r <= 1'b0;
    end else begin
      fg_r <= fg_sel;
      bg_r <= bg_sel;
      op_r <= op_field;
      bpp_r <= bpp_field;
      solid_r <= solid_sel;
      expand_r <= expand_sel;
      key_r <= key_sel;
      pat_bad_r <= pat_width_bad;
    end
  end

  //==============================================================
  // line start walker
  //==============================================================
  // start reloads the destination; each line adds the offset
  // start wins so a new blit never inherits an old line position
  always_comb begin
    line_start_nxt = line_start_r;
    if (blit_start) begin
      line_start_nxt = dest_r;
    end else if (line_advance) begin
      line_start_nxt = 21'(line_start_r + {10'h000, ofs_r});
    end
  end

  // walker register; offset feeds only this walker and blit_line_offset
  always_ff @(posedge clock) begin
    if (rst) begin
      line_start_r <= 21'h00_0000;
    end else begin
      line_start_r <= line_start_nxt;
    end
  end

  //==============================================================
  // output drive
  //==============================================================
  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign response = response_r;
  assign blit_dest_addr = dest_r;
  assign blit_line_start = line_start_r;
  // offset leaves only toward the blit engine
  assign blit_line_offset = ofs_r;
  assign blit_width_m1 = width_r;
  assign blit_height_m1 = height_r;
  assign blit_fg_color = fg_r;
  assign blit_bg_color = bg_r;
  assign blit_op_code = op_r;
  assign blit_bpp16 = bpp_r;
  assign blit_solid_fill = solid_r;
  assign blit_color_expand = expand_r;
  assign blit_key_en = key_r;

endmodule
`default_nettype wire

// ### dv/blitgc_host_model.sv
// Purpose: host bus master that programs the blit parameters
// Assumes: avalon-mm master, requests launched right after a rising edge
// Notes: no wait limit here; the bench watchdog cuts hangs
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// host master
//==============================================================
module blitgc_host_model (
  input wire logic clock,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  input wire logic [1:0] response,
  output logic [11:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  // idle bus at time zero
  initial {address, read, write, writedata, byteenable} = 50'h0;
  // one access; everything held until waitrequest is sampled low
  task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] d,
                      input logic be, output logic [31:0] rdata, output logic [1:0] resp);
    @(posedge clock);
    address <= a;
    writedata <= {24'h00_0000, d};
    byteenable <= {3'h0, be};
    read <= rd;
    write <= !rd;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rdata = readdata;
    resp = response;
    read <= 1'b0;
    write <= 1'b0;
    // scramble released data
    writedata <= ~writedata;
  endtask
endmodule
`default_nettype wire

// ### dv/blitgc_regs_props.sv
// Purpose: concurrent checks on the blit parameter register bank ports
// Assumes: single clock, synchronous active-high reset, one wait cycle per access
// Notes: engine outputs lag a stored byte by one clock
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// checker
//==============================================================
module blitgc_regs_props #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  input wire logic blit_start,
  input wire logic line_advance,
  input wire logic [20:0] blit_dest_addr,
  input wire logic [20:0] blit_line_start,
  input wire logic [10:0] blit_line_offset,
  input wire logic [9:0] blit_width_m1,
  input wire logic [9:0] blit_height_m1,
  input wire logic [15:0] blit_fg_color,
  input wire logic [3:0] blit_op_code,
  input wire logic blit_bpp16,
  input wire logic blit_solid_fill,
  input wire logic blit_color_expand
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // a completed, enabled byte write to one register
  sequence wr_done(logic [11:0] a);
    !waitrequest && write && byteenable[0] && address == ADDR_W'(a);
  endsequence
  // one wait cycle, then a one-cycle answer
  chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait");
  chk_ack_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("answer cycle too long");
  chk_dest_low: assert property (wr_done(12'h420) |-> ##2
    blit_dest_addr[7:0] == $past(writedata[7:0], 2)) else $error("dest low byte wrong");
  chk_dest_upper: assert property (wr_done(12'h428) |-> ##2
    blit_dest_addr[20:16] == $past(writedata[4:0], 2)) else $error("dest upper field wrong");
  chk_offset_upper: assert property (wr_done(12'h434) |-> ##2
    blit_line_offset[10:8] == $past(writedata[2:0], 2)) else $error("offset upper wrong");
  chk_width_low: assert property (wr_done(12'h440) |-> ##2
    blit_width_m1[7:0] == $past(writedata[7:0], 2)) else $error("width low byte wrong");
  chk_height_upper: assert property (wr_done(12'h44c) |-> ##2
    blit_height_m1[9:8] == $past(writedata[1:0], 2)) else $error("height upper wrong");
  chk_unmapped_err: assert property (!waitrequest && address == ADDR_W'(12'h400)
    |-> response == 2'h2) else $error("unmapped access not refused");
  chk_line_load: assert property (blit_start |=>
    blit_line_start == $past(blit_dest_addr)) else $error("line start not loaded");
  chk_line_step: assert property (line_advance && !blit_start |=>
    blit_line_start == 21'($past(blit_line_start) + $past(blit_line_offset)))
    else $error("line start not stepped");
  chk_solid_decode: assert property (blit_op_code == 4'hc && $stable(blit_op_code)
    |-> blit_solid_fill && !blit_color_expand) else $error("solid fill not decoded");
  chk_fg_narrow: assert property (blit_solid_fill && !blit_bpp16 && $stable(blit_bpp16)
    |-> blit_fg_color[15:8] == 8'h00) else $error("8 bpp color not narrowed");
  cov_write: cover property (wr_done(12'h420));
  cov_advance: cover property (line_advance && !blit_start);
  cov_fill16: cover property (blit_solid_fill && blit_bpp16);
endmodule

bind blitgc_regs blitgc_regs_props #(.ADDR_W(ADDR_W)) props_u (.*);
`default_nettype wire

// ### dv/tb.sv
// Purpose: self-checking bench for the blit parameter register bank
// Assumes: host model drives the bus, bench drives the engine strobes
// Notes: expected values come from the register map and depth rules
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// bench top
//==============================================================
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic blit_start = 1'b0;
  logic line_advance = 1'b0;
  logic [11:0] address;
  logic read, write, waitrequest, blit_bpp16, blit_solid_fill, blit_color_expand, blit_key_en;
  logic [31:0] writedata, readdata, rdat;
  logic [3:0] byteenable, blit_op_code, op;
  logic [1:0] response, resp;
  logic [20:0] blit_dest_addr, blit_line_start;
  logic [10:0] blit_line_offset;
  logic [9:0] blit_width_m1, blit_height_m1;
  logic [15:0] blit_fg_color, blit_bg_color, msk;
  int error_cnt = 0;
  int cmp_count = 0;
  // register byte addresses and their implemented bits
  logic [11:0] ra [13] = '{12'h420, 12'h424, 12'h428, 12'h430, 12'h434, 12'h440, 12'h444,
                          12'h448, 12'h44c, 12'h450, 12'h454, 12'h460, 12'h464};
  logic [7:0] rm [13] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'h07, 8'hff, 8'h03, 8'hff, 8'h03,
                         8'hff, 8'hff, 8'hff, 8'hff};
  logic [3:0] ops [9] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};

  always #2 clock = ~clock;

  blitgc_host_model host_u (.*);
  blitgc_regs dut_u (.*);

  //==============================================================
  // helpers
  //==============================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic be = 1'b1);
    host_u.xfer(1'b0, a, d, be, rdat, resp);
  endtask
  task automatic rd(input logic [11:0] a);
    host_u.xfer(1'b1, a, 8'h00, 1'b0, rdat, resp);
  endtask
  // wait out the output lag
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  // one-cycle engine strobes, checked once landed
  task automatic strobe(input logic s, input logic a);
    @(posedge clock);
    blit_start <= s;
    line_advance <= a;
    @(posedge clock);
    blit_start <= 1'b0;
    line_advance <= 1'b0;
    #1;
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well past the test length
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    finish_test();
  end

  //==============================================================
  // test sequence
  //==============================================================
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(ra[i]);
      check(rdat, 32'h0);
      wr(ra[i], 8'hff);
      rd(ra[i]);
      check(rdat, {24'h0, rm[i]});
      check(32'(resp), 32'h0);
    end
    settle();
    check(32'(blit_dest_addr), 32'h1f_ffff);
    check(32'(blit_line_offset), 32'h7ff);
    check(32'({blit_width_m1, blit_height_m1}), 32'hf_ffff);
    // distinct bytes land in their own fields
    wr(12'h420, 8'h12);
    wr(12'h424, 8'h34);
    wr(12'h428, 8'hf5);
    wr(12'h430, 8'h20);
    wr(12'h434, 8'h00);
    wr(12'h448, 8'h07);
    settle();
    check(32'(blit_dest_addr), 32'h15_3412);
    check(32'(blit_line_offset), 32'h020);
    check(32'(blit_height_m1), 32'h307);
    // disabled lane, then unmapped place
    wr(12'h420, 8'h99, 1'b0);
    rd(12'h420);
    check(rdat, 32'h12);
    wr(12'h400, 8'h55);
    check(32'(resp), 32'h2);
    rd(12'h400);
    check(rdat, 32'h0);
    check(32'(resp), 32'h2);
    // walker: load, steps, load beats step, 21-bit wrap
    strobe(1'b1, 1'b0);
    check(32'(blit_line_start), 32'h15_3412);
    strobe(1'b0, 1'b1);
    strobe(1'b0, 1'b1);
    check(32'(blit_line_start), 32'h15_3452);
    strobe(1'b1, 1'b1);
    check(32'(blit_line_start), 32'h15_3412);
    wr(12'h420, 8'hf0);
    wr(12'h424, 8'hff);
    wr(12'h428, 8'h1f);
    settle();
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    check(32'(blit_line_start), 32'h00_0010);
    // colors, and width of two pixels before any pattern fill
    wr(12'h460, 8'hc3);
    wr(12'h464, 8'ha5);
    wr(12'h450, 8'h96);
    wr(12'h454, 8'h3c);
    wr(12'h440, 8'h01);
    wr(12'h444, 8'h00);
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 9; k++) begin
        op = ops[k];
        msk = (b == 1) ? 16'hffff : 16'h00ff;
        wr(12'h470, {3'h0, b[0], op});
        settle();
        check(32'({blit_bpp16, blit_op_code}), 32'({b[0], op}));
        check(32'(blit_fg_color), 32'((op >= 4'h8) ? 16'ha5c3 & msk : 16'h0));
        check(32'(blit_bg_color), 32'((op inside {4'h5, 4'h7, [4'h8:4'hb]}) ?
              16'h3c96 & msk : 16'h0));
        check(32'(blit_solid_fill), 32'(op == 4'hc));
        check(32'(blit_color_expand), 32'(op inside {[4'h8:4'hb]}));
        check(32'(blit_key_en), 32'(op inside {4'h5, 4'h7, 4'h9, 4'hb}));
        rd(12'h474);
        check(rdat, 32'({op inside {4'h5, 4'h7, 4'h9, 4'hb}, op inside {[4'h8:4'hb]},
              op == 4'hc}));
      end
    end
    // too narrow a pattern fill sets the flag
    wr(12'h440, 8'h00);
    wr(12'h470, 8'h06);
    rd(12'h474);
    check(rdat, 32'h8);
    finish_test();
  end
endmodule
`default_nettype wire
